// file: logic/spimsf_pkg.sv
// Shared constants and types for the framed serial port
package spimsf_pkg;
	// Register bus
	localparam int AXI_ADDR_W = 5;
	localparam logic [4:0] ADDR_STAT = 5'h00;
	localparam logic [4:0] ADDR_CON1 = 5'h04;
	localparam logic [4:0] ADDR_CON2 = 5'h08;
	localparam logic [4:0] ADDR_BUF = 5'h0c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Status/control field positions
	localparam int STAT_EN = 15;
	localparam int STAT_SIDL = 13;
	localparam int STAT_ROV = 6;
	localparam int STAT_TBF = 1;
	localparam int STAT_RBF = 0;

	// Control one field positions
	localparam int C1_CLK_DIS = 12;
	localparam int C1_OUT_DIS = 11;
	localparam int C1_WIDTH = 10;
	localparam int C1_SMP = 9;
	localparam int C1_EDGE = 8;
	localparam int C1_SEL_EN = 7;
	localparam int C1_POL = 6;
	localparam int C1_MASTER = 5;
	localparam int C1_SPRE_LSB = 2;
	localparam int C1_PPRE_LSB = 0;

	// Control two field positions
	localparam int C2_FRAMED = 15;
	localparam int C2_FDIR = 14;
	localparam int C2_FPOL = 13;
	localparam int C2_FDLY = 1;

	// Writable masks and reset values
	localparam logic [15:0] CON1_MASK = 16'h1fff;
	localparam logic [15:0] CON2_MASK = 16'he002;
	localparam logic [15:0] CON1_RST = 16'h0000;
	localparam logic [15:0] CON2_RST = 16'h0000;
	localparam logic [15:0] DATA_RST = 16'h0000;

	// Word lengths in bits
	localparam logic [4:0] BITS_WORD = 5'h10;
	localparam logic [4:0] BITS_BYTE = 5'h08;

	// Primary prescale terminal counts: codes 0..3 give 64:1, 16:1, 4:1, 1:1
	localparam logic [5:0] PRI_LIM [4] = '{6'h3f, 6'h0f, 6'h03, 6'h00};
	// Secondary prescale ratio is 8 minus the code
	localparam logic [2:0] SEC_TOP = 3'h7;

	typedef enum {ST_IDLE, ST_SYNC, ST_SHIFT, ST_TAIL} spimsf_state_type;
endpackage

// file: logic/spimsf_core.sv
// Framed master/slave serial port with an AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns

// How it works
// RQ1 - A 16-bit shift register moves data; buffer registers exchange words with software.
// RQ2 - Master drives the shift clock pin; slave takes it as an input.
// RQ3 - Enable bit 15 turns the port on and claims the pins; clear disables.
// RQ4 - Idle-stop bit 13 freezes the port while the device idles.
// RQ5 - Word finishing while the last is unread is dropped; overflow bit 6 sets.
// RQ6 - Transmit-full bit 1 sets on buffer write, clears when shifting starts; an unframed slave clears it as soon as it is idle.
// RQ7 - Receive-full bit 0 sets on word arrival, clears on buffer read.
// RQ8 - Master clock-disable bit 12 stops the clock and releases the pin.
// RQ9 - Output-disable bit 11 releases the data output pin.
// RQ10 - Width bit 10 picks 16-bit or 8-bit transfers.
// RQ11 - Master sample-phase bit 9 samples at end or middle of data time.
// RQ12 - Edge bit 8 chooses which clock transition changes output data.
// RQ13 - Polarity bit 6 sets idle clock high when set, low when clear.
// RQ14 - Slave select-enable bit 7 makes the port obey the active-low select.
// RQ15 - Master-enable bit 5 picks master or slave operation.
// RQ16 - Software never sets both prescalers to undivided.
// RQ17 - Framed bit 15 runs the clock freely; select carries frame sync.
// RQ18 - Software keeps select-enable clear while framed operation is on.
// RQ19 - Software programs the edge bit to zero in framed operation.
// RQ20 - Frame-direction bit 14 makes sync an input when set, output when clear.
// RQ21 - Frame-polarity bit 13 makes sync active high when set, low when clear.
// RQ22 - Frame-delay bit 1 puts sync on the first bit or one clock before.
// RQ23 - Master clock divides system clock by primary then secondary prescaler.
module spimsf_core (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// AXI4-Lite write address
	input wire logic [spimsf_pkg::AXI_ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	// AXI4-Lite read address
	input wire logic [spimsf_pkg::AXI_ADDR_W-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	// Device power state
	input wire logic i_cpu_idle,
	// Serial pins
	input wire logic i_shift_clock_pin,
	output logic o_shift_clock_pin,
	output logic o_shift_clock_pin_oe,
	input wire logic i_serial_in_pin,
	output logic o_serial_out_pin,
	output logic o_serial_out_pin_oe,
	input wire logic i_slave_select_pin_n,
	output logic o_slave_select_pin,
	output logic o_slave_select_pin_oe
);
	import spimsf_pkg::*;

	logic [15:0] con1_reg, con2_reg, txh_reg, rxh_reg, sr_reg;
	logic en_reg, sidl_reg, rov_reg, tbf_reg, rbf_reg;
	logic sdo_reg, sck_act_reg, fs_reg, sck_prev_reg;
	logic [4:0] cnt_reg;
	logic [5:0] pcnt_reg;
	logic [2:0] scnt_reg;
	spimsf_state_type state_reg;
	logic [2:0] meta_reg, sync_reg;
	logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
	logic [AXI_ADDR_W-1:0] awaddr_reg;
	logic [15:0] wdata_reg;
	logic [1:0] wstrb_reg, bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;

	function automatic logic top_of(input logic [15:0] v, input logic w);
		return w ? v[15] : v[7];
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d,
		input logic [1:0] s);
		return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction

	// Two-flop synchronisers for clock, data in and select
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			logic pin;
			assign pin = (g == 0) ? i_shift_clock_pin :
				(g == 1) ? i_serial_in_pin : i_slave_select_pin_n;
			always_ff @(posedge i_ref_clk) begin
				if (i_rst) begin
					meta_reg[g] <= 1'b0;
					sync_reg[g] <= 1'b0;
				end else begin
					meta_reg[g] <= pin;
					sync_reg[g] <= meta_reg[g];
				end
			end
		end
	endgenerate

	logic sck_s, sdi_s, ss_s;
	assign sck_s = sync_reg[0];
	assign sdi_s = sync_reg[1];
	assign ss_s = sync_reg[2];

	logic master, framed, cke, sample_phase, cpol, wide, select_enable, clock_pin_disable, output_pin_disable, fdir, fpol, fdly;
	logic [4:0] nbits;
	// RQ15 master or slave
	assign master = con1_reg[C1_MASTER];
	assign framed = con2_reg[C2_FRAMED];
	// RQ19 edge ignored framed
	assign cke = con1_reg[C1_EDGE] & ~framed;
	// RQ11 master-only sample phase
	assign sample_phase = con1_reg[C1_SMP] & master;
	assign cpol = con1_reg[C1_POL];
	// RQ10 word width select
	assign wide = con1_reg[C1_WIDTH];
	assign nbits = wide ? BITS_WORD : BITS_BYTE;
	assign select_enable = con1_reg[C1_SEL_EN] & ~framed;
	assign clock_pin_disable = con1_reg[C1_CLK_DIS];
	assign output_pin_disable = con1_reg[C1_OUT_DIS];
	assign fdir = con2_reg[C2_FDIR];
	assign fpol = con2_reg[C2_FPOL];
	assign fdly = con2_reg[C2_FDLY];

	// RQ4 idle stop freeze
	logic halt, run_ok;
	assign halt = sidl_reg & i_cpu_idle;
	assign run_ok = en_reg & ~halt;

	// Master clock runs during a word, or always when framed
	logic mclk_on, toggle, tick, pt;
	logic [5:0] pri_lim;
	logic [2:0] sec_lim;
	assign mclk_on = en_reg & master & ~clock_pin_disable &
		(framed | state_reg == ST_SHIFT | state_reg == ST_TAIL);
	assign pri_lim = PRI_LIM[con1_reg[C1_PPRE_LSB +: 2]];
	assign sec_lim = SEC_TOP - con1_reg[C1_SPRE_LSB +: 3];
	assign pt = pcnt_reg == pri_lim;
	assign tick = mclk_on & ~halt & pt & (scnt_reg == sec_lim);
	assign toggle = tick & (framed | state_reg != ST_TAIL);

	// RQ23 primary then secondary divide
	always_ff @(posedge i_ref_clk) begin
		if (i_rst | ~mclk_on) begin
			pcnt_reg <= 6'h00;
			scnt_reg <= 3'h0;
		end else if (~halt) begin
			pcnt_reg <= pt ? 6'h00 : pcnt_reg + 6'h01;
			if (pt) begin
				scnt_reg <= (scnt_reg == sec_lim) ? 3'h0 : scnt_reg + 3'h1;
			end
		end
	end

	// RQ8 clock stops when disabled
	always_ff @(posedge i_ref_clk) begin
		if (i_rst | ~mclk_on) begin
			sck_act_reg <= 1'b0;
		end else if (toggle) begin
			sck_act_reg <= ~sck_act_reg;
		end
	end

	// Slave edge detection on the synchronised pin, active level made polarity-free
	logic s_act, lead_ev, trail_ev, tail_ev;
	assign s_act = sck_s ^ cpol;
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			sck_prev_reg <= 1'b0;
		end else begin
			sck_prev_reg <= s_act;
		end
	end
	// RQ2 clock source by mode
	assign lead_ev = run_ok & (master ? (toggle & ~sck_act_reg) : (s_act & ~sck_prev_reg));
	assign trail_ev = run_ok & (master ? (toggle & sck_act_reg) : (~s_act & sck_prev_reg));
	assign tail_ev = tick & state_reg == ST_TAIL;

	// Start conditions
	logic fs_in, sel_ok, idle, st_mast, st_slv, st_fmo, st_fsi;
	// RQ21 sync polarity on input
	assign fs_in = ss_s == fpol;
	// RQ14 slave select gating
	assign sel_ok = ~select_enable | ~ss_s;
	assign idle = state_reg == ST_IDLE;
	assign st_mast = idle & master & ~framed & ~clock_pin_disable & tbf_reg & run_ok;
	assign st_slv = idle & ~master & ~framed & sel_ok & lead_ev;
	// RQ20 sync direction
	assign st_fmo = idle & framed & ~fdir & tbf_reg & trail_ev;
	assign st_fsi = idle & framed & fdir & lead_ev & fs_in;

	// RQ6 transmit word taken when shifting starts, or at once by an idle unframed slave
	logic load_now;
	assign load_now = run_ok & tbf_reg & (st_mast | (idle & ~master & ~framed) |
		((st_fmo | st_fsi) & fdly) | (state_reg == ST_SYNC & trail_ev));

	// Edge actions
	logic do_lead, do_trail, last, samp, drive, done, rd_buf;
	logic [15:0] sr_cur, sr_sh, word;
	assign do_lead = lead_ev & (state_reg == ST_SHIFT | st_slv | (st_fsi & fdly));
	assign do_trail = trail_ev & state_reg == ST_SHIFT;
	assign last = cnt_reg == nbits;
	// RQ11 sample point choice
	assign samp = (do_lead & (cke ? ~sample_phase : (sample_phase & cnt_reg != 5'h00))) |
		(do_trail & (cke ? sample_phase : ~sample_phase)) | (tail_ev & ~cke & sample_phase);
	// RQ12 output change edge
	assign drive = (do_lead & ~cke) | (do_trail & cke & ~last) |
		(load_now & cke & ~do_lead);
	assign sr_cur = load_now ? txh_reg : sr_reg;
	assign sr_sh = {sr_cur[14:0], sdi_s};
	assign done = tail_ev | (do_trail & last & ~master);
	assign word = (samp ? sr_sh : sr_reg) & (wide ? 16'hffff : 16'h00ff);

	// Transfer sequencer
	always_ff @(posedge i_ref_clk) begin
		if (i_rst | ~en_reg | (~master & ~framed & ~sel_ok)) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 5'h00;
		end else begin
			if (do_lead) begin
				cnt_reg <= cnt_reg + 5'h01;
			end
			unique case (state_reg)
				ST_IDLE: begin
					if (st_mast | st_slv | ((st_fmo | st_fsi) & fdly)) begin
						state_reg <= ST_SHIFT;
					end else if (st_fmo | st_fsi) begin
						state_reg <= ST_SYNC;
					end
				end
				ST_SYNC: begin
					if (trail_ev) begin
						state_reg <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (do_trail & last) begin
						state_reg <= master ? ST_TAIL : ST_IDLE;
						cnt_reg <= master ? cnt_reg : 5'h00;
					end
				end
				ST_TAIL: begin
					if (tail_ev) begin
						state_reg <= ST_IDLE;
						cnt_reg <= 5'h00;
					end
				end
			endcase
		end
	end

	// RQ1 shift register and data output
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			sr_reg <= DATA_RST;
			sdo_reg <= 1'b0;
		end else begin
			if (samp) begin
				sr_reg <= sr_sh;
			end else if (load_now) begin
				sr_reg <= txh_reg;
			end
			if (drive) begin
				sdo_reg <= top_of(samp ? sr_sh : sr_cur, wide);
			end
		end
	end

	// RQ22 sync one clock early or on first bit
	always_ff @(posedge i_ref_clk) begin
		if (i_rst | ~en_reg | ~framed) begin
			fs_reg <= 1'b0;
		end else if (st_fmo) begin
			fs_reg <= 1'b1;
		end else if (trail_ev & (state_reg == ST_SHIFT |
			(state_reg == ST_SYNC & ~fdir))) begin
			fs_reg <= fdly ? 1'b0 : state_reg == ST_SYNC;
		end
	end

	// AXI4-Lite handshakes
	logic aw_hs, w_hs, ar_hs, do_write;
	assign o_s_axi_awready = ~aw_full_reg & ~bvalid_reg;
	assign o_s_axi_wready = ~w_full_reg & ~bvalid_reg;
	assign o_s_axi_arready = ~rvalid_reg;
	assign aw_hs = i_s_axi_awvalid & o_s_axi_awready;
	assign w_hs = i_s_axi_wvalid & o_s_axi_wready;
	assign ar_hs = i_s_axi_arvalid & o_s_axi_arready;
	assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign rd_buf = ar_hs & i_s_axi_araddr == ADDR_BUF;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			awaddr_reg <= '0;
			wdata_reg <= DATA_RST;
			wstrb_reg <= 2'h0;
		end else begin
			if (aw_hs) begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= i_s_axi_awaddr;
			end
			if (w_hs) begin
				w_full_reg <= 1'b1;
				wdata_reg <= i_s_axi_wdata[15:0];
				wstrb_reg <= i_s_axi_wstrb[1:0];
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= (awaddr_reg > ADDR_BUF || awaddr_reg[1:0] != 2'h0) ?
					RESP_SLVERR : RESP_OKAY;
			end else if (bvalid_reg & i_s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Configuration and data registers
	logic [15:0] stat_now, wr_stat;
	logic wr_st, wr_c1, wr_c2, wr_buf;
	assign stat_now = {en_reg, 1'b0, sidl_reg, 6'h00, rov_reg, 4'h0, tbf_reg, rbf_reg};
	assign wr_stat = merge(stat_now, wdata_reg, wstrb_reg);
	assign wr_st = do_write & awaddr_reg == ADDR_STAT;
	assign wr_c1 = do_write & awaddr_reg == ADDR_CON1;
	assign wr_c2 = do_write & awaddr_reg == ADDR_CON2;
	assign wr_buf = do_write & awaddr_reg == ADDR_BUF & wstrb_reg != 2'h0;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			con1_reg <= CON1_RST;
			con2_reg <= CON2_RST;
			en_reg <= 1'b0;
			sidl_reg <= 1'b0;
			txh_reg <= DATA_RST;
		end else begin
			if (wr_c1) begin
				con1_reg <= merge(con1_reg, wdata_reg, wstrb_reg) & CON1_MASK;
			end
			if (wr_c2) begin
				con2_reg <= merge(con2_reg, wdata_reg, wstrb_reg) & CON2_MASK;
			end
			// RQ3 port enable
			if (wr_st) begin
				en_reg <= wr_stat[STAT_EN];
				sidl_reg <= wr_stat[STAT_SIDL];
			end
			if (wr_buf) begin
				txh_reg <= merge(txh_reg, wdata_reg, wstrb_reg);
			end
		end
	end

	// Status flags; a hardware set wins over a same-cycle clear
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			tbf_reg <= 1'b0;
			rbf_reg <= 1'b0;
			rov_reg <= 1'b0;
			rxh_reg <= DATA_RST;
		end else begin
			// RQ6 transmit full flag
			if (wr_buf) begin
				tbf_reg <= 1'b1;
			end else if (load_now) begin
				tbf_reg <= 1'b0;
			end
			// RQ5 overflow drops the word
			if (done & rbf_reg & ~rd_buf) begin
				rov_reg <= 1'b1;
			end else if (wr_st & ~wr_stat[STAT_ROV]) begin
				rov_reg <= 1'b0;
			end
			// RQ7 receive full flag
			if (done & ~(rbf_reg & ~rd_buf)) begin
				rxh_reg <= word;
				rbf_reg <= 1'b1;
			end else if (rd_buf) begin
				rbf_reg <= 1'b0;
			end
		end
	end

	// Read channel
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= RESP_OKAY;
			unique case (i_s_axi_araddr)
				ADDR_STAT: rdata_reg <= {16'h0000, stat_now};
				ADDR_CON1: rdata_reg <= {16'h0000, con1_reg};
				ADDR_CON2: rdata_reg <= {16'h0000, con2_reg};
				ADDR_BUF: rdata_reg <= {16'h0000, rxh_reg};
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= RESP_SLVERR;
				end
			endcase
		end else if (i_s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign o_s_axi_bvalid = bvalid_reg;
	assign o_s_axi_bresp = bresp_reg;
	assign o_s_axi_rvalid = rvalid_reg;
	assign o_s_axi_rdata = rdata_reg;
	assign o_s_axi_rresp = rresp_reg;

	// Pins
	// RQ13 idle clock level
	assign o_shift_clock_pin = sck_act_reg ^ cpol;
	// RQ8 clock pin released
	assign o_shift_clock_pin_oe = en_reg & master & ~clock_pin_disable;
	assign o_serial_out_pin = sdo_reg;
	// RQ9 data output release
	assign o_serial_out_pin_oe = en_reg & ~output_pin_disable & (master | framed | ~select_enable | ~ss_s);
	// RQ17 frame sync on select pin
	assign o_slave_select_pin = fs_reg ~^ fpol;
	assign o_slave_select_pin_oe = en_reg & framed & ~fdir;
endmodule

// file: verif/spimsf_core_properties.sv
// Register bus handshake properties of the framed serial port
`timescale 1ns/1ns
module spimsf_core_properties import spimsf_pkg::*; (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Write channels
	input wire logic i_s_axi_awvalid,
	input wire logic o_s_axi_awready,
	input wire logic i_s_axi_wvalid,
	input wire logic o_s_axi_wready,
	input wire logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	// Read channels
	input wire logic [spimsf_pkg::AXI_ADDR_W-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	input wire logic o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic [1:0] o_s_axi_rresp,
	input wire logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence s_wr_both;
		i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
	endsequence
	sequence s_rd_bad;
		i_s_axi_arvalid && o_s_axi_arready && (i_s_axi_araddr > 5'h0c);
	endsequence
	AST_B_AFTER_WR: assert property (s_wr_both |-> ##2 o_s_axi_bvalid)
		else $error("write response late");
	AST_B_DROP: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
		else $error("write response stuck");
	AST_W_BLOCK: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write taken during response");
	AST_R_AFTER_AR: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read data late");
	AST_R_DROP: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
		else $error("read data stuck");
	AST_AR_BLOCK: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read taken during data");
	AST_R_BAD: assert property (s_rd_bad |=> o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 0)
		else $error("unmapped read not refused");
	AST_R_UPPER: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
endmodule

// file: verif/spimsf_peer.sv
// Peer device on the serial link, clock idle low, shifts on falling edge
`timescale 1ns/1ns
module spimsf_peer (
	// Link pins
	input wire logic i_sck,
	input wire logic i_mosi,
	output logic o_miso,
	// Bench control
	input wire logic i_load,
	input wire logic i_wide,
	input wire logic [15:0] i_tx_word,
	output logic [15:0] o_rx_word
);
	logic [15:0] tx_reg = 16'h0000;
	// samples on rising clock, MSB first
	always @(posedge i_sck) o_rx_word <= {o_rx_word[14:0], i_mosi};
	// next bit after the active-to-idle edge
	always @(negedge i_sck or posedge i_load) begin
		if (i_load)
			tx_reg <= i_wide ? i_tx_word : {i_tx_word[7:0], 8'h00};
		else
			tx_reg <= {tx_reg[14:0], ~tx_reg[15]};
	end
	assign o_miso = tx_reg[15];
endmodule

// file: verif/spimsf_core_test.sv
// Self-checking bench for the framed serial port
`timescale 1ns/1ns
module spimsf_core_test;
	import spimsf_pkg::*;
	logic i_ref_clk = 0;
	logic i_rst = 1;
	logic [AXI_ADDR_W-1:0] i_s_axi_awaddr = '0, i_s_axi_araddr = '0;
	logic [31:0] i_s_axi_wdata = '0, o_s_axi_rdata, rd;
	logic [3:0] i_s_axi_wstrb = 4'hf;
	logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
	logic i_s_axi_arvalid = 0, i_s_axi_rready = 0, i_cpu_idle = 0;
	logic i_shift_clock_pin = 0, i_slave_select_pin_n = 1, i_serial_in_pin;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
	logic o_shift_clock_pin, o_shift_clock_pin_oe, o_serial_out_pin, o_serial_out_pin_oe;
	logic o_slave_select_pin, o_slave_select_pin_oe;
	logic load = 0, wide = 0;
	logic [15:0] peer_tx = '0, peer_rx;
	int n_errors = 0, n_compared = 0;
	wire link_sck = o_shift_clock_pin_oe ? o_shift_clock_pin : i_shift_clock_pin;
	wire link_mosi = o_serial_out_pin_oe ? o_serial_out_pin : 1'b1;

	spimsf_core i_dut (.*);
	spimsf_peer i_peer (.i_sck(link_sck), .i_mosi(link_mosi), .o_miso(i_serial_in_pin),
		.i_load(load), .i_wide(wide), .i_tx_word(peer_tx), .o_rx_word(peer_rx));

	initial begin
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	task automatic complete_run;
		$display("TB: counts errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [AXI_ADDR_W-1:0] a, input logic [15:0] d, input logic [1:0] er);
		logic aw, w, done;
		logic [1:0] rs;
		int k;
		@(posedge i_ref_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= {16'h0000, d};
		i_s_axi_awvalid <= 1'b1;
		i_s_axi_wvalid <= 1'b1;
		i_s_axi_bready <= 1'b1;
		done = 0;
		for (k = 0; k < 50 && !done; k++) begin
			@(negedge i_ref_clk);
			aw = o_s_axi_awready;
			w = o_s_axi_wready;
			done = o_s_axi_bvalid;
			rs = o_s_axi_bresp;
			@(posedge i_ref_clk);
			if (aw)
				i_s_axi_awvalid <= 1'b0;
			if (w)
				i_s_axi_wvalid <= 1'b0;
		end
		i_s_axi_bready <= 1'b0;
		if (!done) begin
			n_errors++;
			complete_run();
		end
		check({30'h0, rs}, {30'h0, er});
	endtask

	task automatic rdr(input logic [AXI_ADDR_W-1:0] a, input logic [1:0] er);
		logic ar, done;
		logic [1:0] rs;
		int k;
		@(posedge i_ref_clk);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'b1;
		i_s_axi_rready <= 1'b1;
		done = 0;
		for (k = 0; k < 50 && !done; k++) begin
			@(negedge i_ref_clk);
			ar = o_s_axi_arready;
			done = o_s_axi_rvalid;
			rd = o_s_axi_rdata;
			rs = o_s_axi_rresp;
			@(posedge i_ref_clk);
			if (ar)
				i_s_axi_arvalid <= 1'b0;
		end
		i_s_axi_rready <= 1'b0;
		if (!done) begin
			n_errors++;
			complete_run();
		end
		check({30'h0, rs}, {30'h0, er});
	endtask

	task automatic wait_stat(input int bit_pos);
		int k;
		for (k = 0; k < 200; k++) begin
			rdr(ADDR_STAT, RESP_OKAY);
			if (rd[bit_pos] === 1'b1)
				return;
		end
		n_errors++;
		complete_run();
	endtask

	// Configure, preload the peer, then hand one word to the port
	task automatic send(input logic [15:0] c1, input logic [15:0] word,
		input logic [15:0] pword);
		wr(ADDR_CON1, c1, RESP_OKAY);
		@(posedge i_ref_clk);
		wide <= c1[C1_WIDTH];
		peer_tx <= pword;
		load <= 1'b1;
		@(posedge i_ref_clk);
		load <= 1'b0;
		wr(ADDR_BUF, word, RESP_OKAY);
	endtask

	task automatic t_reset;
		rdr(ADDR_CON1, RESP_OKAY);
		check(rd, 32'h0);
		rdr(ADDR_CON2, RESP_OKAY);
		check(rd, 32'h0);
		rdr(ADDR_STAT, RESP_OKAY);
		check(rd, 32'h0);
		wr(5'h10, 16'hffff, RESP_SLVERR);
		rdr(5'h10, RESP_SLVERR);
		check(rd, 32'h0);
		$display("TB: reset test done");
	endtask

	task automatic t_pins;
		wr(ADDR_CON1, 16'h017e, RESP_OKAY);
		repeat (2) @(negedge i_ref_clk);
		check({o_shift_clock_pin_oe, o_serial_out_pin_oe}, 32'h0);
		wr(ADDR_STAT, 16'h8000, RESP_OKAY);
		repeat (2) @(negedge i_ref_clk);
		check({o_shift_clock_pin_oe, o_serial_out_pin_oe}, 32'h3);
		check({31'h0, o_shift_clock_pin}, 32'h1);
		wr(ADDR_CON1, 16'h197e, RESP_OKAY);
		repeat (2) @(negedge i_ref_clk);
		check({o_shift_clock_pin_oe, o_serial_out_pin_oe}, 32'h0);
		wr(ADDR_CON1, 16'h003e, RESP_OKAY);
		wr(ADDR_CON2, 16'ha000, RESP_OKAY);
		repeat (2) @(negedge i_ref_clk);
		check({o_slave_select_pin_oe, o_slave_select_pin}, 32'h2);
		wr(ADDR_CON2, 16'hc000, RESP_OKAY);
		repeat (2) @(negedge i_ref_clk);
		check({31'h0, o_slave_select_pin_oe}, 32'h0);
		wr(ADDR_CON2, 16'h0000, RESP_OKAY);
		$display("TB: pin test done");
	endtask

	task automatic t_byte;
		send(16'h013e, 16'h00a5, 16'h003c);
		wait_stat(STAT_RBF);
		check(rd, 32'h8001);
		check({24'h0, peer_rx[7:0]}, 32'ha5);
		rdr(ADDR_BUF, RESP_OKAY);
		check(rd, 32'h003c);
		rdr(ADDR_STAT, RESP_OKAY);
		check(rd, 32'h8000);
		$display("TB: byte test done");
	endtask

	task automatic t_overflow;
		send(16'h053e, 16'h1234, 16'hbeef);
		wait_stat(STAT_RBF);
		check({16'h0, peer_rx}, 32'h1234);
		send(16'h053e, 16'h5678, 16'h0f0f);
		wait_stat(STAT_ROV);
		rdr(ADDR_BUF, RESP_OKAY);
		check(rd, 32'hbeef);
		wr(ADDR_STAT, 16'h8000, RESP_OKAY);
		rdr(ADDR_STAT, RESP_OKAY);
		check(rd, 32'h8000);
		$display("TB: overflow test done");
	endtask

	task automatic t_idle;
		wr(ADDR_STAT, 16'ha000, RESP_OKAY);
		@(posedge i_ref_clk);
		i_cpu_idle <= 1'b1;
		send(16'h013e, 16'h0081, 16'h0042);
		repeat (200) @(posedge i_ref_clk);
		rdr(ADDR_STAT, RESP_OKAY);
		check(rd, 32'ha002);
		i_cpu_idle <= 1'b0;
		wait_stat(STAT_RBF);
		rdr(ADDR_BUF, RESP_OKAY);
		check(rd, 32'h0042);
		$display("TB: idle test done");
	endtask

	// Slave byte; the bench makes a 320 ns link clock, still outside the frame
	task automatic t_slave;
		send(16'h0100, 16'h005a, 16'h00c3);
		repeat (8) begin
			repeat (4) @(posedge i_ref_clk);
			i_shift_clock_pin <= 1'b1;
			repeat (4) @(posedge i_ref_clk);
			i_shift_clock_pin <= 1'b0;
		end
		wait_stat(STAT_RBF);
		check(rd, 32'ha001);
		check({24'h0, peer_rx[7:0]}, 32'h5a);
		rdr(ADDR_BUF, RESP_OKAY);
		check(rd, 32'h00c3);
		$display("TB: slave test done");
	endtask

	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		t_reset();
		t_pins();
		t_byte();
		t_overflow();
		t_idle();
		t_slave();
		complete_run();
	end

	initial begin
		repeat (60000) @(posedge i_ref_clk);
		n_errors++;
		complete_run();
	end
endmodule

bind spimsf_core spimsf_core_properties i_props (.*);
